// ---- logic/tfr_pkg.sv ----
// constants and types shared by the translation fault exit recorder
package tfr_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] DETAIL_LO_OFS = 8'h00;
  localparam logic [7:0] DETAIL_HI_OFS = 8'h04;
  localparam logic [7:0] LINEAR_LO_OFS = 8'h08;
  localparam logic [7:0] LINEAR_HI_OFS = 8'h0c;
  localparam logic [7:0] PHYS_LO_OFS   = 8'h10;
  localparam logic [7:0] PHYS_HI_OFS   = 8'h14;
  localparam logic [7:0] STATUS_OFS    = 8'h18;
  localparam logic [7:0] CONTROL_OFS   = 8'h1c;

  // ****************************************
  // exit-detail word fields
  // ****************************************
  localparam int DET_READ_BIT      = 0;
  localparam int DET_WRITE_BIT     = 1;
  localparam int DET_FETCH_BIT     = 2;
  localparam int DET_PERM_LSB      = 3;
  localparam int DET_LIN_VALID_BIT = 7;
  localparam int DET_LIN_XLATE_BIT = 8;
  localparam int DET_UNBLOCK_BIT   = 12;
  localparam int DET_VECTOR_MSB    = 7;
  localparam int DET_OFFSET_MSB    = 11;
  localparam int ADDR32_MSB        = 31;

  // ****************************************
  // status and control fields, reset values
  // ****************************************
  localparam int STAT_NEW_BIT      = 0;
  localparam int STAT_KIND_LSB     = 4;
  localparam int CTL_ENABLE_BIT    = 0;
  localparam int CTL_RMW_READ_BIT  = 1;
  localparam logic [31:0] DATA_RESET    = 32'h0000_0000;
  localparam logic [1:0]  CONTROL_RESET = 2'h3;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // ****************************************
  // exit kinds
  // ****************************************
  typedef enum logic [2:0] {
    EXIT_TRANSLATION_VIOLATION,
    EXIT_TRANSLATION_MISCONFIG,
    EXIT_END_OF_INTERRUPT,
    EXIT_VIC_WRITE,
    EXIT_LOAD_MSW,
    EXIT_STRING_IO,
    EXIT_OTHER
  } tfr_exit_kind_type;

endpackage : tfr_pkg

// ---- logic/tfr_exit_recorder.sv ----
// exit-detail, linear-address and physical-address capture with wishbone register access
//
// Notes on behaviour
// - bit 0 set when the violating access was a data read
// - bit 1 set when the violating access was a data write
// - bit 2 set when the violating access was an instruction fetch
// - bits 5:3 are AND of read, write, execute bits of all walk entries; the code combines only entries flagged in walkUsed
// - any non-present walk entry forces bits 5:3 to zero; the code ignores entries not flagged in walkUsed
// - bit 7 marks linear address valid, except page_dir_pointer_entry loads
// - with bit 7 set, bit 8 says access was a linear translation
// - bit 8 zero when bit 7 zero; bits 6, 11:9, 63:13 always zero
// - with accessed/dirty tracking, paging-structure access sets bits 0 and 1
// - read-modify-write sets bit 1; bit 0 per configurable policy
// - bit 12 undefined when nonmaskable exiting without virtual control, or vectoring valid
// - otherwise bit 12 set for interrupt_return access with relevant blocking active
// - end_of_interrupt exits: bits 7:0 hold dismissed vector, rest zero
// - controller write exits: bits 11:0 hold page offset, rest zero
// - load_machine_status_word exit: linear field is operand address, upper cleared outside 64-bit
// - string port exits: segment base plus index; input extra, output data or override
// - violations with bit 7: linear field from faulting access, upper cleared outside 64-bit
// - violation or misconfiguration: physical field holds offending guest-physical address
// - detail may be undefined for branch or precise_sampling_record store accesses
//
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps

module tfr_exit_recorder #(
  parameter int LEVELS = 4
) (
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       reset_n,
  // exit event and kind
  input  wire logic                       exitValid,
  input  wire tfr_pkg::tfr_exit_kind_type exitKind,
  input  wire logic                       longMode,
  // violating access description
  input  wire logic                       dataRead,
  input  wire logic                       dataWrite,
  input  wire logic                       instrFetch,
  input  wire logic                       readModifyWrite,
  input  wire logic                       pagingStructAccess,
  input  wire logic                       accessDirtyEnable,
  input  wire logic                       linearTranslation,
  input  wire logic                       pageDirPointerEntryLoad,
  input  wire logic                       debugStoreRecord,
  // translation walk entries
  input  wire logic [LEVELS-1:0][2:0]     walkPerm,
  input  wire logic [LEVELS-1:0]          walkPresent,
  input  wire logic [LEVELS-1:0]          walkUsed,
  // nonmaskable unblocking context
  input  wire logic                       nonmaskableExitCtl,
  input  wire logic                       virtualNonmaskableCtl,
  input  wire logic                       vectoringValid,
  input  wire logic                       interruptReturnAccess,
  input  wire logic                       nonmaskableBlocked,
  input  wire logic                       virtualNonmaskableBlocked,
  // virtualization exit data
  input  wire logic [7:0]                 dismissedVector,
  input  wire logic [11:0]                writePageOffset,
  // address sources
  input  wire logic [63:0]                faultLinearAddr,
  input  wire logic [63:0]                guestPhysAddr,
  input  wire logic [63:0]                statusWordOperandAddr,
  input  wire logic                       portIsInput,
  input  wire logic                       segmentUsable,
  input  wire logic                       segmentOverride,
  input  wire logic [63:0]                extraSegmentBase,
  input  wire logic [63:0]                dataSegmentBase,
  input  wire logic [63:0]                overrideSegmentBase,
  input  wire logic [63:0]                destIndexReg,
  input  wire logic [63:0]                srcIndexReg,
  // wishbone slave
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [7:0]                 wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic [31:0]                     wb_dat_o,
  output logic                            wb_ack_o,
  // capture indication
  output logic                            exitCaptured
);

  // ****************************************
  // elaboration checks
  // ****************************************
  // the walk combines at most eight levels; a zero-level walk has nothing to combine
  generate
    if (LEVELS < 1 || LEVELS > 8) begin : g_bad_levels
      $error("LEVELS must lie between 1 and 8");
    end
  endgenerate

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [63:0] modeAddr(input logic [63:0] addr, input logic wide);
    modeAddr = wide ? addr : {32'h0000_0000, addr[tfr_pkg::ADDR32_MSB:0]};
  endfunction : modeAddr

  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nu,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = nu[b*8 +: 8];
      end
    end
    laneMerge = res;
  endfunction : laneMerge

  // the two low address bits pick a byte lane only, so registers match on the word address
  function automatic logic regHit(input logic [7:0] adr, input logic [7:0] ofs);
    regHit = (adr[7:2] == ofs[7:2]);
  endfunction : regHit

  // ****************************************
  // registers
  // ****************************************
  logic [63:0]                detail_r;
  logic [63:0]                detail_nxt;
  logic [63:0]                linear_r;
  logic [63:0]                linear_nxt;
  logic [63:0]                phys_r;
  logic [63:0]                phys_nxt;
  logic                       newExit_r;
  tfr_pkg::tfr_exit_kind_type kind_r;
  logic [1:0]                 control_r;
  logic                       captureEnable;
  logic                       rmwSetsRead;
  logic                       capture;

  assign captureEnable = control_r[tfr_pkg::CTL_ENABLE_BIT];
  assign rmwSetsRead   = control_r[tfr_pkg::CTL_RMW_READ_BIT];
  assign capture       = exitValid && captureEnable;

  // ****************************************
  // walk permission accumulation
  // ****************************************
  // unused levels pass all ones so a short walk is not penalised
  logic [LEVELS:0][2:0] permChain;
  logic [LEVELS:0]      presentChain;

  assign permChain[0]    = 3'h7;
  assign presentChain[0] = 1'b1;

  genvar lv;
  generate
    for (lv = 0; lv < LEVELS; lv++) begin : g_walk
      assign permChain[lv+1]    = permChain[lv] & (walkUsed[lv] ? walkPerm[lv] : 3'h7);
      assign presentChain[lv+1] = presentChain[lv] & (walkPresent[lv] | ~walkUsed[lv]);
    end
  endgenerate

  // ****************************************
  // violation detail word
  // ****************************************
  logic [63:0] violationDetail;
  logic        treatAsWrite;
  logic        linValid;
  logic        unblockDefined;
  logic        unblockActive;

  // paging-structure accesses under tracking behave as writes
  assign treatAsWrite   = accessDirtyEnable && pagingStructAccess;
  assign linValid       = !pageDirPointerEntryLoad;
  // where bit 12 is undefined it is reported as zero for determinism
  assign unblockDefined = !((nonmaskableExitCtl && !virtualNonmaskableCtl) || vectoringValid);
  assign unblockActive  = virtualNonmaskableCtl ? virtualNonmaskableBlocked : nonmaskableBlocked;

  always_comb begin
    violationDetail = 64'h0000_0000_0000_0000;
    violationDetail[tfr_pkg::DET_READ_BIT] = dataRead || treatAsWrite
                                           || (readModifyWrite && rmwSetsRead);
    violationDetail[tfr_pkg::DET_WRITE_BIT] = dataWrite || treatAsWrite
                                            || readModifyWrite;
    violationDetail[tfr_pkg::DET_FETCH_BIT] = instrFetch;
    violationDetail[tfr_pkg::DET_PERM_LSB +: 3] = presentChain[LEVELS] ? permChain[LEVELS] : 3'h0;
    violationDetail[tfr_pkg::DET_LIN_VALID_BIT] = linValid;
    violationDetail[tfr_pkg::DET_LIN_XLATE_BIT] = linValid && linearTranslation;
    violationDetail[tfr_pkg::DET_UNBLOCK_BIT] = unblockDefined && interruptReturnAccess
                                              && unblockActive;
    if (debugStoreRecord) begin
      // undefined case: report a clean zero word
      violationDetail = 64'h0000_0000_0000_0000;
    end
  end

  // ****************************************
  // string port linear address
  // ****************************************
  logic [63:0] stringBase;
  logic [63:0] stringIndex;
  logic [63:0] stringAddr;

  always_comb begin
    if (portIsInput) begin
      stringBase  = extraSegmentBase;
      stringIndex = destIndexReg;
    end else begin
      stringBase  = segmentOverride ? overrideSegmentBase : dataSegmentBase;
      stringIndex = srcIndexReg;
    end
    stringAddr = stringBase + stringIndex;
  end

  // ****************************************
  // next capture values per exit kind
  // ****************************************
  // undefined fields are written as zero rather than left stale
  always_comb begin
    detail_nxt = 64'h0000_0000_0000_0000;
    linear_nxt = 64'h0000_0000_0000_0000;
    phys_nxt   = 64'h0000_0000_0000_0000;
    unique case (exitKind)
      tfr_pkg::EXIT_TRANSLATION_VIOLATION: begin
        detail_nxt = violationDetail;
        if (linValid) begin
          linear_nxt = modeAddr(faultLinearAddr, longMode);
        end
        phys_nxt = guestPhysAddr;
      end
      tfr_pkg::EXIT_TRANSLATION_MISCONFIG: begin
        phys_nxt = guestPhysAddr;
      end
      tfr_pkg::EXIT_END_OF_INTERRUPT: begin
        detail_nxt[tfr_pkg::DET_VECTOR_MSB:0] = dismissedVector;
      end
      tfr_pkg::EXIT_VIC_WRITE: begin
        detail_nxt[tfr_pkg::DET_OFFSET_MSB:0] = writePageOffset;
      end
      tfr_pkg::EXIT_LOAD_MSW: begin
        linear_nxt = modeAddr(statusWordOperandAddr, longMode);
      end
      tfr_pkg::EXIT_STRING_IO: begin
        if (segmentUsable) begin
          linear_nxt = modeAddr(stringAddr, longMode);
        end
      end
      default: begin
        detail_nxt = 64'h0000_0000_0000_0000;
      end
    endcase
  end

  // ****************************************
  // capture registers
  // ****************************************
  // all three fields load on the same edge so software never sees a mix
  // with capture disabled the last record stays for software to read
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      detail_r <= 64'h0000_0000_0000_0000;
      linear_r <= 64'h0000_0000_0000_0000;
      phys_r   <= 64'h0000_0000_0000_0000;
      kind_r   <= tfr_pkg::EXIT_OTHER;
    end else if (capture) begin
      detail_r <= detail_nxt;
      linear_r <= linear_nxt;
      phys_r   <= phys_nxt;
      kind_r   <= exitKind;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      exitCaptured <= 1'b0;
    end else begin
      exitCaptured <= capture;
    end
  end

  // ****************************************
  // wishbone slave
  // ****************************************
  logic        busReq;
  logic        busWrite;
  logic [31:0] readData;

  // ack comes one cycle after the request and drops the cycle after
  assign busReq   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign busWrite = busReq && wb_we_i;

  always_comb begin
    unique case ({wb_adr_i[7:2], 2'b00})
      tfr_pkg::DETAIL_LO_OFS: readData = detail_r[31:0];
      tfr_pkg::DETAIL_HI_OFS: readData = detail_r[63:32];
      tfr_pkg::LINEAR_LO_OFS: readData = linear_r[31:0];
      tfr_pkg::LINEAR_HI_OFS: readData = linear_r[63:32];
      tfr_pkg::PHYS_LO_OFS:   readData = phys_r[31:0];
      tfr_pkg::PHYS_HI_OFS:   readData = phys_r[63:32];
      tfr_pkg::STATUS_OFS:    readData = {25'h0, kind_r, 3'h0, newExit_r};
      tfr_pkg::CONTROL_OFS:   readData = {30'h0, control_r};
      default:                readData = tfr_pkg::UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= tfr_pkg::DATA_RESET;
    end else begin
      wb_ack_o <= busReq;
      if (busReq && !wb_we_i) begin
        wb_dat_o <= readData;
      end
    end
  end

  // ****************************************
  // control and status registers
  // ****************************************
  logic        controlWrite;
  logic        statusClear;
  logic [31:0] controlMerged;

  assign controlWrite  = busWrite && regHit(wb_adr_i, tfr_pkg::CONTROL_OFS);
  assign statusClear   = busWrite && regHit(wb_adr_i, tfr_pkg::STATUS_OFS)
                         && wb_sel_i[0] && wb_dat_i[tfr_pkg::STAT_NEW_BIT];
  // merged on the full word so each lane keeps its own byte enable
  assign controlMerged = laneMerge({30'h0, control_r}, wb_dat_i, wb_sel_i);

  // control: byte lane 0 holds both bits
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      control_r <= tfr_pkg::CONTROL_RESET;
    end else if (controlWrite) begin
      control_r <= controlMerged[1:0];
    end
  end

  // new-exit flag: write one to clear, a capture in the same cycle wins
  // so software that clears late never loses an exit it has not yet seen
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      newExit_r <= 1'b0;
    end else if (capture) begin
      newExit_r <= 1'b1;
    end else if (statusClear) begin
      newExit_r <= 1'b0;
    end
  end

endmodule : tfr_exit_recorder

// ---- dv/tfr_exit_recorder_properties.sv ----
// checker for bus and capture timing of the exit recorder
`timescale 1ns/1ps

module tfr_exit_recorder_checker (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        reset_n,
  // watched ports
  input wire logic        exitValid,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        exitCaptured
);
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // a request counts only while ack is low, the slave ignores stb during ack
  logic take;
  assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  chk_ack_after_take:
    assert property (take |=> wb_ack_o) else $error("no ack after request");
  chk_ack_one_cycle:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  chk_ack_needs_request:
    assert property ($rose(wb_ack_o) |-> $past(take)) else $error("ack without request");
  chk_read_data_held:
    assert property (!(take && !wb_we_i) |=> $stable(wb_dat_o)) else $error("read data moved");
  chk_detail_high_zero:
    assert property (take && !wb_we_i && wb_adr_i == tfr_pkg::DETAIL_HI_OFS |=> wb_dat_o == 32'h0)
      else $error("detail high word not zero");
  chk_unmapped_reads_zero:
    assert property (take && !wb_we_i && wb_adr_i >= 8'h20 |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
  chk_capture_has_cause:
    assert property (exitCaptured |-> $past(exitValid)) else $error("capture without exit");
  chk_capture_one_pulse:
    assert property (exitCaptured && !exitValid |=> !exitCaptured) else $error("capture pulse too long");
endmodule : tfr_exit_recorder_checker

bind tfr_exit_recorder tfr_exit_recorder_checker i_chk (
  .core_clk(core_clk), .reset_n(reset_n), .exitValid(exitValid), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .exitCaptured(exitCaptured));

// ---- dv/tb_tfr_exit_recorder.sv ----
// self-checking bench for the translation fault exit recorder
`timescale 1ns/1ps

module tb_tfr_exit_recorder;
  // ****************************************
  // signals
  // ****************************************
  logic core_clk, reset_n, exitValid, longMode, dataRead, dataWrite, instrFetch, readModifyWrite;
  logic pagingStructAccess, accessDirtyEnable, linearTranslation, pageDirPointerEntryLoad, debugStoreRecord;
  logic nonmaskableExitCtl, virtualNonmaskableCtl, vectoringValid, interruptReturnAccess, nonmaskableBlocked;
  logic virtualNonmaskableBlocked, portIsInput, segmentUsable, segmentOverride, wb_cyc_i, wb_stb_i, wb_we_i;
  logic wb_ack_o, exitCaptured;
  logic [3:0][2:0]            walkPerm;
  logic [3:0]                 walkPresent, walkUsed, wb_sel_i;
  logic [7:0]                 dismissedVector, wb_adr_i;
  logic [11:0]                writePageOffset;
  logic [31:0]                wb_dat_i, wb_dat_o, rdData;
  logic [63:0]                faultLinearAddr, guestPhysAddr, statusWordOperandAddr, extraSegmentBase;
  logic [63:0]                dataSegmentBase, overrideSegmentBase, destIndexReg, srcIndexReg;
  logic [4:0]                 nmiCase [5] = '{5'h04, 5'h1a, 5'h0b, 5'h02, 5'h14};
  tfr_pkg::tfr_exit_kind_type exitKind;
  int                         errCount, totalChecks;

  tfr_exit_recorder #(.LEVELS(4)) i_dut (.*);

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_sel_i <= 4'hf;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1) @(posedge core_clk);
    rdData = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    totalChecks++;
    if (g !== e) begin
      errCount++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp

  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(rdData, e);
  endtask : chk

  task automatic chk64(input logic [7:0] a, input logic [63:0] e);
    chk(a, e[31:0]);
    chk(a + 8'h4, e[63:32]);
  endtask : chk64

  // access flags drop back after every exit, so each test sets only what it needs
  task automatic clr();
    {dataRead, dataWrite, instrFetch, readModifyWrite, pagingStructAccess, accessDirtyEnable, linearTranslation,
     pageDirPointerEntryLoad, interruptReturnAccess, nonmaskableBlocked, virtualNonmaskableCtl, debugStoreRecord,
     virtualNonmaskableBlocked, vectoringValid, portIsInput, segmentOverride, longMode} <= '0;
    walkPerm    <= {4{3'h7}};
    walkPresent <= 4'hf;
  endtask : clr

  task automatic ex(input tfr_pkg::tfr_exit_kind_type k, input logic cap);
    exitKind  <= k;
    exitValid <= 1'b1;
    @(posedge core_clk);
    exitValid <= 1'b0;
    clr();
    @(posedge core_clk);
    cmp({31'h0, exitCaptured}, {31'h0, cap});
  endtask : ex

  task automatic finish_test();
    $display("checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  // ****************************************
  // tests
  // ****************************************
  initial begin
    {reset_n, exitValid, wb_cyc_i, wb_stb_i, wb_we_i, nonmaskableExitCtl} = '0;
    exitKind = tfr_pkg::EXIT_OTHER;
    {wb_adr_i, wb_dat_i, segmentUsable, walkUsed, wb_sel_i} = {40'h0, 9'h1ff};
    {dismissedVector, writePageOffset, faultLinearAddr} = {8'ha5, 12'hfed, 64'h1234_5678_9abc_def0};
    {guestPhysAddr, statusWordOperandAddr} = {64'hfedc_ba98_7654_3210, 64'h8765_4321_0fed_cba9};
    {extraSegmentBase, dataSegmentBase, overrideSegmentBase} = {64'h1_0000_1000, 64'h5000, 64'h3000};
    {destIndexReg, srcIndexReg, errCount, totalChecks} = {64'h20, 64'h4, 64'h0};
    clr();
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    chk(tfr_pkg::CONTROL_OFS, 32'h3);
    chk(tfr_pkg::STATUS_OFS, 32'h60);
    chk64(tfr_pkg::DETAIL_LO_OFS, 64'h0);
    $display("test reset values done");
    {dataRead, linearTranslation} <= 2'h3;
    {walkPerm[2], walkPerm[3], walkUsed, walkPresent} <= {3'h5, 3'h0, 8'h77};
    ex(tfr_pkg::EXIT_TRANSLATION_VIOLATION, 1'b1);
    chk64(tfr_pkg::DETAIL_LO_OFS, 64'h1a9);
    chk64(tfr_pkg::LINEAR_LO_OFS, 64'h9abc_def0);
    chk64(tfr_pkg::PHYS_LO_OFS, 64'hfedc_ba98_7654_3210);
    chk(tfr_pkg::STATUS_OFS, 32'h1);
    {dataWrite, linearTranslation, pageDirPointerEntryLoad, longMode} <= 4'hf;
    {walkUsed, walkPresent} <= 8'hfb;
    ex(tfr_pkg::EXIT_TRANSLATION_VIOLATION, 1'b1);
    chk64(tfr_pkg::DETAIL_LO_OFS, 64'h2);
    $display("test access kinds done");
    for (int i = 0; i < 5; i++) begin
      {nonmaskableExitCtl, virtualNonmaskableCtl, nonmaskableBlocked, virtualNonmaskableBlocked,
       vectoringValid} <= nmiCase[i];
      {instrFetch, interruptReturnAccess, linearTranslation, longMode} <= 4'hf;
      ex(tfr_pkg::EXIT_TRANSLATION_VIOLATION, 1'b1);
      chk(tfr_pkg::DETAIL_LO_OFS, (i < 2) ? 32'h11bc : 32'h1bc);
    end
    chk64(tfr_pkg::LINEAR_LO_OFS, 64'h1234_5678_9abc_def0);
    $display("test unblocking done");
    {pagingStructAccess, accessDirtyEnable} <= 2'h3;
    ex(tfr_pkg::EXIT_TRANSLATION_VIOLATION, 1'b1);
    chk(tfr_pkg::DETAIL_LO_OFS, 32'hbb);
    readModifyWrite <= 1'b1;
    ex(tfr_pkg::EXIT_TRANSLATION_VIOLATION, 1'b1);
    chk(tfr_pkg::DETAIL_LO_OFS, 32'hbb);
    bus(1'b1, tfr_pkg::CONTROL_OFS, 32'h1);
    readModifyWrite <= 1'b1;
    ex(tfr_pkg::EXIT_TRANSLATION_VIOLATION, 1'b1);
    chk(tfr_pkg::DETAIL_LO_OFS, 32'hba);
    bus(1'b1, tfr_pkg::CONTROL_OFS, 32'h3);
    $display("test write tracking done");
    dataRead <= 1'b1;
    ex(tfr_pkg::EXIT_END_OF_INTERRUPT, 1'b1);
    chk64(tfr_pkg::DETAIL_LO_OFS, 64'ha5);
    ex(tfr_pkg::EXIT_VIC_WRITE, 1'b1);
    chk64(tfr_pkg::DETAIL_LO_OFS, 64'hfed);
    ex(tfr_pkg::EXIT_LOAD_MSW, 1'b1);
    chk64(tfr_pkg::LINEAR_LO_OFS, 64'h0fed_cba9);
    chk(tfr_pkg::STATUS_OFS, 32'h41);
    {portIsInput, longMode} <= 2'h3;
    ex(tfr_pkg::EXIT_STRING_IO, 1'b1);
    chk64(tfr_pkg::LINEAR_LO_OFS, 64'h1_0000_1020);
    segmentOverride <= 1'b1;
    ex(tfr_pkg::EXIT_STRING_IO, 1'b1);
    chk64(tfr_pkg::LINEAR_LO_OFS, 64'h3004);
    ex(tfr_pkg::EXIT_STRING_IO, 1'b1);
    chk64(tfr_pkg::LINEAR_LO_OFS, 64'h5004);
    segmentUsable <= 1'b0;
    ex(tfr_pkg::EXIT_STRING_IO, 1'b1);
    chk64(tfr_pkg::LINEAR_LO_OFS, 64'h0);
    segmentUsable <= 1'b1;
    $display("test exit kinds done");
    guestPhysAddr <= 64'h1_2345_6000;
    ex(tfr_pkg::EXIT_TRANSLATION_MISCONFIG, 1'b1);
    chk64(tfr_pkg::PHYS_LO_OFS, 64'h1_2345_6000);
    bus(1'b1, tfr_pkg::STATUS_OFS, 32'h1);
    chk(tfr_pkg::STATUS_OFS, 32'h10);
    bus(1'b1, tfr_pkg::CONTROL_OFS, 32'h0);
    guestPhysAddr <= 64'h0;
    ex(tfr_pkg::EXIT_TRANSLATION_VIOLATION, 1'b0);
    bus(1'b1, tfr_pkg::PHYS_LO_OFS, 32'hffff_ffff);
    chk64(tfr_pkg::PHYS_LO_OFS, 64'h1_2345_6000);
    chk(tfr_pkg::STATUS_OFS, 32'h10);
    chk(8'h20, 32'h0);
    bus(1'b1, tfr_pkg::CONTROL_OFS, 32'h3);
    {debugStoreRecord, dataRead} <= 2'h3;
    ex(tfr_pkg::EXIT_TRANSLATION_VIOLATION, 1'b1);
    chk(tfr_pkg::DETAIL_LO_OFS, 32'h0);
    $display("test hold and refusal done");
    finish_test();
  end

  // a full run takes well under 2000 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    errCount++;
    finish_test();
  end
endmodule : tb_tfr_exit_recorder
